/* verif/core_model.sv */
// instruction sequencer model: fetches and core strobes
`timescale 1ns/10ps
module core_model (
  input logic clk_i,
  output logic [14:0] addr_o,
  output logic [7:0] data_o,
  output logic prog_o,
  output logic [4:0] stb_o,
  output logic [7:0] sp_o
);
  initial {addr_o, data_o, prog_o, stb_o, sp_o} = '0;
  // stb bits: return_from_interrupt_instruction, pop, vectoring, clear, opcode load
  task op(input logic [4:0] k, input logic [14:0] a, input logic [7:0] d, input logic p,
    input logic [7:0] s);
    begin
      @(posedge clk_i);
      stb_o <= k;
      addr_o <= a;
      data_o <= d;
      prog_o <= p;
      sp_o <= s;
      @(posedge clk_i);
      stb_o <= 5'h00;
      // released bus shows no stale byte
      data_o <= ~d;
      #1;
    end
  endtask
endmodule // core_model

/* verif/trap_and_edge_interrupt_logic_test.sv */
// self-checking bench for the trap and port edge interrupt block
`timescale 1ns/10ps
`include "trap_int_regs.vh"
module trap_and_edge_interrupt_logic_test;
  logic ref_clk = 0;
  logic srst = 1;
  logic [7:0] pins = 8'h00;
  logic lp = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0] r;
  wire [14:0] fa;
  wire [7:0] md, sp;
  wire mp;
  wire [4:0] stb;
  int err_total = 0, num_checks = 0;
  always #20 ref_clk = ~ref_clk;
  core_model core (.clk_i(ref_clk), .addr_o(fa), .data_o(md), .prog_o(mp), .stb_o(stb), .sp_o(sp));
  trap_edge_int DUT (.ref_clk_i(ref_clk), .srst_i(srst), .port_pin_i(pins), .fetch_addr_i(fa),
    .mem_data_i(md), .mem_programmed_i(mp), .ir_load_i(stb[0]), .pop_i(stb[3]), .sp_i(sp),
    .clear_pending_instruction_i(stb[1]), .vectoring_instruction_i(stb[2]), .return_from_interrupt_instruction_i(stb[4]),
    .pc_i(15'h0000), .low_power_i(lp), .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(),
    .wdata_i(wdata), .wstrb_i(4'hF), .wvalid_i(wvalid), .wready_o(), .bresp_o(), .bvalid_o(),
    .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(), .rdata_o(),
    .rresp_o(), .rvalid_o(), .rready_i(rready), .ir_o(), .trap_take_o(), .push_addr_o(),
    .port_irq_o(), .pc_low_o(), .pc_low_load_o(), .pc_force_o(), .pc_force_val_o(), .wake_o(),
    .wake_to_isr_o());
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input bit ok, input string m);
    begin
      num_checks++;
      if (!ok)
      begin
        err_total++;
        $display("CHECK FAILED %0t %s", $time, m);
      end
      if (m == "timeout")
        end_sim;
    end
  endtask
  // master holds each channel until its own handshake edge
  task wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    begin
      @(posedge ref_clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
      for (n = 0; n < 40 && !DUT.bvalid_o; n++)
      begin
        @(posedge ref_clk);
        if (DUT.awready_o) awvalid <= 0;
        if (DUT.wready_o) wvalid <= 0;
      end
      bready <= 0;
      if (n == 40) chk(0, "timeout");
      chk(DUT.bresp_o === `RESP_OKAY, "write response");
    end
  endtask
  task rc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    begin
      @(posedge ref_clk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      for (n = 0; n < 40 && !DUT.rvalid_o; n++)
      begin
        @(posedge ref_clk);
        if (DUT.arready_o) arvalid <= 0;
      end
      {d, r} = {DUT.rdata_o, DUT.rresp_o};
      rready <= 0;
      if (n == 40) chk(0, "timeout");
      chk(d[7:0] === e && r === er, "register read");
    end
  endtask
  task vec(input logic [7:0] e);
    begin
      core.op(5'h04, 0, 8'h55, 1, 0);
      chk(DUT.pc_low_load_o === 1'b1 && DUT.pc_low_o === e, "vector code");
    end
  endtask
  task wirq(input logic e);
    int n;
    begin
      for (n = 0; n < 12 && DUT.port_irq_o !== e; n++) @(posedge ref_clk);
      if (n == 12) chk(0, "timeout");
      #1;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task s_trap;
    begin
      rc(`OFF_WAKE_PEND, 8'h00, `RESP_OKAY);
      rc(4'h2, 8'h00, `RESP_SLVERR);
      wr(`OFF_CTRL, 32'h1);
      core.op(5'h01, 15'h0123, `TRAP_OPCODE, 1, 0);
      chk(DUT.trap_take_o === 1'b1 && DUT.push_addr_o === 15'h0123, "trap push");
      rc(`OFF_CTRL, 8'h01, `RESP_OKAY);
      vec(`VEC_TRAP);
      core.op(5'h02, 0, 8'h55, 1, 0);
      core.op(5'h02, 0, 8'h55, 1, 0);
      vec(`VEC_DEFAULT);
      core.op(5'h10, 0, 8'h55, 1, 0);
      core.op(5'h01, 15'h1000, 8'hAA, 1, 0);
      chk(DUT.ir_o === 8'h00 && DUT.trap_take_o === 1'b1, "absent memory");
      core.op(5'h08, 0, 8'h55, 1, 8'h6E);
      chk(DUT.pc_force_o === 1'b1 && DUT.pc_force_val_o === 15'h7FFF, "underflow");
      core.op(5'h08, 0, 8'h55, 1, 8'h70);
      chk(DUT.pc_force_o === 1'b0, "legal pop");
      core.op(5'h01, 15'h7FFF, 8'h3C, 0, 0);
      chk(DUT.trap_take_o === 1'b1 && DUT.push_addr_o === 15'h7FFF, "top trap");
      core.op(5'h02, 0, 8'h55, 1, 0);
    end
  endtask
  task s_port;
    begin
      wr(`OFF_CTRL, 32'h3);
      wr(`OFF_WAKE_EN, 32'h3);
      wr(`OFF_WAKE_EDGE, 32'h2);
      @(posedge ref_clk) pins <= 8'h03;
      wirq(1);
      rc(`OFF_WAKE_PEND, 8'h01, `RESP_OKAY);
      @(posedge ref_clk) pins <= 8'h01;
      repeat (6) @(posedge ref_clk);
      rc(`OFF_WAKE_PEND, 8'h03, `RESP_OKAY);
      core.op(5'h01, 15'h0200, `TRAP_OPCODE, 1, 0);
      wirq(0);
      vec(`VEC_TRAP);
      core.op(5'h02, 0, 8'h55, 1, 0);
      wirq(1);
      vec(`VEC_PORT);
      rc(`OFF_CTRL, 8'h07, `RESP_OKAY);
      chk(DUT.port_irq_o === 1'b0, "service blocks port");
      core.op(5'h10, 0, 8'h55, 1, 0);
      @(posedge ref_clk) lp <= 1;
      repeat (3) @(posedge ref_clk);
      #1 chk(DUT.wake_o === 1'b1 && DUT.wake_to_isr_o === 1'b1, "wake to service");
      wr(`OFF_CTRL, 32'h0);
      #1 chk(DUT.wake_o === 1'b1 && DUT.wake_to_isr_o === 1'b0 && DUT.port_irq_o === 1'b0,
        "plain wake");
      wr(`OFF_WAKE_PEND, 32'h3);
      @(posedge ref_clk) lp <= 0;
      rc(`OFF_WAKE_PEND, 8'h00, `RESP_OKAY);
      vec(`VEC_DEFAULT);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge ref_clk);
    srst <= 0;
    s_trap;
    s_port;
    end_sim;
  end
endmodule // trap_and_edge_interrupt_logic_test

/* verif/trap_edge_int_chk.sv */
// concurrent checks on the trap and port edge interrupt block
`timescale 1ns/10ps
module trap_edge_int_chk (
  input logic ref_clk_i,
  input logic srst_i,
  input logic [14:0] fetch_addr_i,
  input logic [7:0] mem_data_i,
  input logic mem_programmed_i,
  input logic ir_load_i,
  input logic pop_i,
  input logic [7:0] sp_i,
  input logic clear_pending_instruction_i,
  input logic vectoring_instruction_i,
  input logic low_power_i,
  input logic [7:0] ir_o,
  input logic trap_take_o,
  input logic [14:0] push_addr_o,
  input logic port_irq_o,
  input logic [7:0] pc_low_o,
  input logic pc_low_load_o,
  input logic pc_force_o,
  input logic [14:0] pc_force_val_o,
  input logic wake_o,
  input logic wake_to_isr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  logic zop;
  logic flag;
  // the core sees a zero byte whenever memory is absent
  assign zop = ir_load_i && (mem_data_i == 8'h00 || !mem_programmed_i || fetch_addr_i > 15'h0FFF);
  // mirror of the hidden flag; set wins over clear
  always @(posedge ref_clk_i)
    if (srst_i)
      flag <= 1'b0;
    else if (zop)
      flag <= 1'b1;
    else if (clear_pending_instruction_i)
      flag <= 1'b0;
  ////////////////////////////////////////////////////////////////////////////
  trap_take_a: assert property (zop |=> trap_take_o && push_addr_o == $past(fetch_addr_i))
    else $error("trap not taken at its fetch address");
  ir_absent_a: assert property (ir_load_i && !mem_programmed_i |=> ir_o == 8'h00)
    else $error("absent word not read as zero");
  underflow_a: assert property (pop_i && sp_i < 8'h6F |=> pc_force_o && pc_force_val_o == 15'h7FFF)
    else $error("stack underflow did not force pc");
  trap_vector_a: assert property (vectoring_instruction_i && flag |=> pc_low_load_o && pc_low_o == 8'hFE)
    else $error("trap vector not chosen");
  even_code_a: assert property (vectoring_instruction_i && !flag && !zop
    |=> pc_low_load_o && !pc_low_o[0] && pc_low_o >= 8'hE0 && pc_low_o != 8'hFE)
    else $error("bad vector code");
  trap_blocks_a: assert property ($past(flag) |-> !port_irq_o)
    else $error("port request while trap pending");
  wake_gate_a: assert property (!low_power_i |=> !wake_o)
    else $error("wake outside low power");
  isr_wake_a: assert property (wake_to_isr_o |-> wake_o)
    else $error("service wake without wake");
  cover property (zop ##1 trap_take_o);
  cover property (vectoring_instruction_i && !flag ##1 pc_low_o == 8'hE2);
  cover property (wake_to_isr_o);
endmodule // trap_edge_int_chk

bind trap_edge_int trap_edge_int_chk u_chk (.*);

/* verilog/edge_bit.v */
// one port line edge detector and pending latch
`timescale 1ns/10ps
module edge_bit (
  input wire ref_clk_i,
  input wire srst_i,
  input wire pin_i,
  input wire falling_i,
  input wire clear_i,
  output reg pend_o
);
  reg sync1;
  reg sync2;
  reg prev;
  wire trig;

  assign trig = falling_i ? (prev & ~sync2) : (~prev & sync2);

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      prev <= 1'b0;
      pend_o <= 1'b0;
    end
    else
    begin
      sync1 <= pin_i;
      sync2 <= sync1;
      prev <= sync2;
      // set wins over a software clear in the same cycle
      if (trig)
        pend_o <= 1'b1;
      else if (clear_i)
        pend_o <= 1'b0;
    end
  end
endmodule // edge_bit

/* verilog/fetch_guard.v */
// program fetch guard: absent memory and stack underflow handling
`timescale 1ns/10ps
`include "trap_int_regs.vh"
module fetch_guard (
  input wire [14:0] fetch_addr_i,
  input wire [7:0] mem_data_i,
  input wire mem_programmed_i,
  input wire pop_i,
  input wire [7:0] sp_i,
  output wire [7:0] opcode_o,
  output wire pc_force_o,
  output wire [14:0] pc_force_val_o
);
  // beyond implemented space or unprogrammed reads as zero
  assign opcode_o = ((fetch_addr_i > `PC_TOP_IMPL) || !mem_programmed_i) ?
    `TRAP_OPCODE : mem_data_i;
  // popping past the floor loads the top program address
  assign pc_force_o = pop_i && (sp_i >= `STACK_FLOOR) && (sp_i != `SP_WRAPPED) ? 1'b0 :
    pop_i;
  assign pc_force_val_o = `PC_ON_UNDERFLOW;
endmodule // fetch_guard

/* verilog/trap_edge_int.v */
// trap pending flag, port edge interrupts and vector arbitration
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "trap_int_regs.vh"
module trap_edge_int (
  input wire ref_clk_i,
  input wire srst_i,
  input wire [7:0] port_pin_i,
  input wire [14:0] fetch_addr_i,
  input wire [7:0] mem_data_i,
  input wire mem_programmed_i,
  input wire ir_load_i,
  input wire pop_i,
  input wire [7:0] sp_i,
  input wire clear_pending_instruction_i,
  input wire vectoring_instruction_i,
  input wire return_from_interrupt_instruction_i,
  input wire [14:0] pc_i,
  input wire low_power_i,
  input wire [3:0] awaddr_i,
  input wire awvalid_i,
  output reg awready_o,
  input wire [31:0] wdata_i,
  input wire [3:0] wstrb_i,
  input wire wvalid_i,
  output reg wready_o,
  output reg [1:0] bresp_o,
  output reg bvalid_o,
  input wire bready_i,
  input wire [3:0] araddr_i,
  input wire arvalid_i,
  output reg arready_o,
  output reg [31:0] rdata_o,
  output reg [1:0] rresp_o,
  output reg rvalid_o,
  input wire rready_i,
  output reg [7:0] ir_o,
  output reg trap_take_o,
  output reg [14:0] push_addr_o,
  output reg port_irq_o,
  output reg [7:0] pc_low_o,
  output reg pc_low_load_o,
  output reg pc_force_o,
  output reg [14:0] pc_force_val_o,
  output reg wake_o,
  output reg wake_to_isr_o
);
  ////////////////////////////////////////////////////////////////////
  reg trap_pending_flag; // internal only, never on the bus
  reg global_interrupt_enable;
  reg port_group_interrupt_enable;
  reg in_service;
  reg [7:0] wake_enable_register;
  reg [7:0] wake_edge_select_register;
  wire [7:0] wake_pending_register;
  reg [7:0] pend_clear;
  wire [7:0] opcode;
  wire force_pc;
  wire [14:0] force_val;
  wire trap_now;
  wire port_req;
  wire any_edge;
  reg aw_got;
  reg w_got;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  genvar gi;

  fetch_guard u_guard (
    .fetch_addr_i(fetch_addr_i),
    .mem_data_i(mem_data_i),
    .mem_programmed_i(mem_programmed_i),
    .pop_i(pop_i),
    .sp_i(sp_i),
    .opcode_o(opcode),
    .pc_force_o(force_pc),
    .pc_force_val_o(force_val)
  );

  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_line
      edge_bit u_bit (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .pin_i(port_pin_i[gi]),
        .falling_i(wake_edge_select_register[gi]),
        .clear_i(pend_clear[gi]),
        .pend_o(wake_pending_register[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  assign trap_now = ir_load_i && (opcode == `TRAP_OPCODE);
  // all eight lines funnel into one request
  assign port_req = |(wake_pending_register & wake_enable_register) &&
    port_group_interrupt_enable && global_interrupt_enable;
  // any enabled pending edge, not gated by the interrupt enables, a pending trap or service
  assign any_edge = |(wake_pending_register & wake_enable_register);

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      trap_pending_flag <= 1'b0;
      in_service <= 1'b0;
      ir_o <= `RST_BYTE;
      trap_take_o <= 1'b0;
      push_addr_o <= 15'h0000;
      port_irq_o <= 1'b0;
      pc_low_o <= `RST_BYTE;
      pc_low_load_o <= 1'b0;
      pc_force_o <= 1'b0;
      pc_force_val_o <= 15'h0000;
      wake_o <= 1'b0;
      wake_to_isr_o <= 1'b0;
    end
    else
    begin
      if (ir_load_i)
        ir_o <= opcode;
      // trap taken at once, even inside a service routine
      trap_take_o <= trap_now;
      if (trap_now)
        push_addr_o <= fetch_addr_i; // address of the trap opcode
      // set beats clear when both land in one cycle
      if (trap_now)
        trap_pending_flag <= 1'b1;
      else if (clear_pending_instruction_i)
        trap_pending_flag <= 1'b0;
      port_irq_o <= port_req && !trap_pending_flag && !in_service;
      if (vectoring_instruction_i && !trap_pending_flag && port_req)
        in_service <= 1'b1;
      else if (return_from_interrupt_instruction_i)
        in_service <= 1'b0;
      pc_low_load_o <= vectoring_instruction_i;
      if (vectoring_instruction_i)
      begin
        if (trap_pending_flag)
          pc_low_o <= `VEC_TRAP;
        else if (port_req)
          pc_low_o <= `VEC_PORT;
        else
          pc_low_o <= `VEC_DEFAULT;
      end
      pc_force_o <= force_pc;
      pc_force_val_o <= force_val;
      // port edge wakes the core; isr first only when enabled
      wake_o <= low_power_i && any_edge;
      wake_to_isr_o <= low_power_i && any_edge && port_req;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read at a time
  always @*
  begin
    pend_clear = 8'h00;
    if (aw_got && w_got && !bvalid_o && aw_addr == `OFF_WAKE_PEND && w_strb[0])
      pend_clear = w_data[7:0]; // write one to clear
  end

  always @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= `RESP_OKAY;
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rresp_o <= `RESP_OKAY;
      rdata_o <= 32'h00000000;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      global_interrupt_enable <= 1'b0;
      port_group_interrupt_enable <= 1'b0;
      wake_enable_register <= `RST_BYTE;
      wake_edge_select_register <= `RST_BYTE;
    end
    else
    begin
      awready_o <= !aw_got && !awready_o && awvalid_i;
      wready_o <= !w_got && !wready_o && wvalid_i;
      if (awvalid_i && awready_o)
      begin
        aw_got <= 1'b1;
        aw_addr <= awaddr_i;
      end
      if (wvalid_i && wready_o)
      begin
        w_got <= 1'b1;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (aw_got && w_got && !bvalid_o)
      begin
        bvalid_o <= 1'b1;
        bresp_o <= `RESP_OKAY;
        if (w_strb[0])
        begin
          case (aw_addr)
            `OFF_CTRL:
            begin
              global_interrupt_enable <= w_data[`CTRL_GIE];
              port_group_interrupt_enable <= w_data[`CTRL_PORT_GROUP_INTERRUPT_ENABLE];
            end
            `OFF_WAKE_EN: wake_enable_register <= w_data[7:0];
            `OFF_WAKE_EDGE: wake_edge_select_register <= w_data[7:0];
            `OFF_WAKE_PEND: ;
            default: bresp_o <= `RESP_SLVERR;
          endcase
        end
      end
      if (bvalid_o && bready_i)
      begin
        bvalid_o <= 1'b0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      arready_o <= !arready_o && !rvalid_o && arvalid_i;
      if (arvalid_i && arready_o)
      begin
        rvalid_o <= 1'b1;
        rresp_o <= `RESP_OKAY;
        rdata_o <= 32'h00000000;
        case (araddr_i)
          `OFF_CTRL:
          begin
            rdata_o[`CTRL_GIE] <= global_interrupt_enable;
            rdata_o[`CTRL_PORT_GROUP_INTERRUPT_ENABLE] <= port_group_interrupt_enable;
            rdata_o[`CTRL_IN_SVC] <= in_service;
          end
          `OFF_WAKE_EN: rdata_o[7:0] <= wake_enable_register;
          `OFF_WAKE_EDGE: rdata_o[7:0] <= wake_edge_select_register;
          `OFF_WAKE_PEND: rdata_o[7:0] <= wake_pending_register;
          default: rresp_o <= `RESP_SLVERR;
        endcase
      end
      else if (rvalid_o && rready_i)
        rvalid_o <= 1'b0;
    end
  end
endmodule // trap_edge_int

/* verilog/trap_int_regs.vh */
// constants for the trap and port edge interrupt logic
`ifndef TRAP_INT_REGS_VH
`define TRAP_INT_REGS_VH
// axi4-lite register byte offsets
`define OFF_CTRL 4'h0
`define OFF_WAKE_EN 4'h4
`define OFF_WAKE_EDGE 4'h8
`define OFF_WAKE_PEND 4'hC
// control register fields
`define CTRL_GIE 0
`define CTRL_PORT_GROUP_INTERRUPT_ENABLE 1
`define CTRL_IN_SVC 2
`define CTRL_TRAP 3
// reset values
`define RST_BYTE 8'h00
// opcodes and vector codes
`define TRAP_OPCODE 8'h00
`define VEC_TRAP 8'hFE
`define VEC_PORT 8'hE2
`define VEC_DEFAULT 8'hE0
// addresses
`define STACK_FLOOR 8'h6F
`define SP_WRAPPED 8'hFF
`define PC_ON_UNDERFLOW 15'h7FFF
`define PC_TOP_IMPL 15'h0FFF
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif
